// ==== common/ind_access_pkg.sv ====
// Purpose: constants for the register access block
// Assumes: 8-bit register bus, byte offsets
// Notes: main-space and indirect-space offsets share one width
package ind_access_pkg;
    // main register space
    localparam logic [7:0] ADDR_IND_CTL = 8'hB0;
    localparam logic [7:0] ADDR_IND_OFS = 8'hB1;
    localparam logic [7:0] ADDR_IND_VAL = 8'hB2;
    localparam logic [7:0] ADDR_PORT0_ID = 8'hF8;
    localparam logic [7:0] ADDR_PORT1_ID = 8'hF9;
    localparam logic [7:0] ADDR_PORT2_ID = 8'hFA;
    localparam logic [7:0] ADDR_PORT3_ID = 8'hFB;
    // indirect control fields
    localparam int CTL_AUTOINC_BIT = 1;
    localparam int CTL_BLOCK_LSB = 2;
    localparam int CTL_BLOCK_MSB = 5;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] OFS_RESET = 8'h00;
    // block select codes
    localparam logic [3:0] BLK_DIGITAL = 4'h0;
    localparam logic [3:0] BLK_LINK0 = 4'h1;
    localparam logic [3:0] BLK_LINK3 = 4'h4;
    localparam logic [3:0] BLK_LINK_SHARE = 4'h5;
    localparam logic [3:0] BLK_LINK_ALL = 4'h6;
    localparam logic [3:0] BLK_TX = 4'h7;
    // last offset of each reserved set
    localparam logic [7:0] LINK_LAST = 8'h14;
    localparam logic [7:0] SHARE_LAST = 8'h04;
    localparam logic [7:0] TX_LAST = 8'h1D;
    // digital page map
    localparam logic [7:0] DIG_PATTERN_GEN_CONTROL = 8'h01;
    localparam logic [7:0] DIG_PATTERN_GEN_CONFIG = 8'h02;
    localparam logic [7:0] DIG_PGEN_LAST = 8'h1F;
    localparam logic [7:0] DIG_TX0_FIRST = 8'h40;
    localparam logic [7:0] DIG_TX0_LAST = 8'h51;
    localparam logic [7:0] DIG_TX1_FIRST = 8'h60;
    localparam logic [7:0] DIG_TX1_LAST = 8'h71;
    localparam int PGEN_ON_BIT = 0;
    localparam int SOLID_BIT = 7;
    localparam int BARS_LSB = 4;
    localparam int BARS_MSB = 5;
    localparam logic [7:0] PATTERN_GEN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PATTERN_GEN_CONFIG_RESET = 8'h33;
    localparam logic [7:0] ID_RESET = 8'h00;
    // indirect memory: 8 blocks of 128 bytes
    localparam int MEM_AW = 10;
    localparam int RSTN_SYNC_LEN = 2;
endpackage : ind_access_pkg

// ==== src/ind_store.sv ====
// Purpose: byte store behind the indirect window
// Assumes: one access per cycle, synchronous write
// Notes: read data come out of a register, one cycle after the request
`timescale 1ns/1ps
module ind_store #(
    parameter int AW = 10
) (
    // clock
    input wire logic i_clk,
    // access
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule : ind_store

// ==== src/indirect_register_access.sv ====
// Purpose: main-space register bank, indirect window, alias address decoders
// Assumes: bus engine presents one byte access per cycle on the register port
// Notes: read data answer one cycle after the strobe, two cycles for window reads served from the store
// Behaviour
// RULE1: ports 1-3 hold 7-bit alias address in bits 7:1, matched transactions reach port.
// RULE2: an alias field of zero disables that port's decoder.
// RULE3: port 0 has the same decoder, one register below port 1.
// RULE4: three main registers 0xB0-0xB2 form control, offset and data window.
// RULE5: host writes control, offset, then data to write indirectly.
// RULE6: host writes control, offset, then reads data to read indirectly.
// RULE7: auto-increment set advances stored offset after each data access.
// RULE8: block field bits 5:2; code 0 is digital page, generator at 0x01-0x1F.
// RULE9: digital page holds transmit timing at 0x40-0x51 and 0x60-0x71.
// RULE10: codes 1 to 4 select link channel sets 0 to 3, offsets 0x00-0x14.
// RULE11: code 5 shared link set, 6 broadcast to all links, 7 transmit set; code 6 writes land only in its own set here.
// RULE12: generator control bit 0 turns pattern on; resets off.
// RULE13: configuration bit 7 picks fixed colour (1) or bars (0); resets to bars.
// RULE14: configuration bits 5:4 give 1, 2, 4 or 8 bars; resets to 3.
// RULE15: auto-increment clear leaves the stored offset unchanged.
`timescale 1ns/1ps
module indirect_register_access
    import ind_access_pkg::*;
#(
    parameter int MEM_ADDR_W = MEM_AW
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    // register port from the serial bus engine
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    // target address of the bus transaction being decoded
    input wire logic I_BUS_TGT_VALID,
    input wire logic [6:0] I_BUS_TGT_ADDR,
    output logic [3:0] O_PORT_HIT,
    // pattern generator controls
    output logic O_TEST_PATTERN_ON,
    output logic O_SOLID_COLOUR_SELECT,
    output logic [1:0] O_BAR_COUNT_CODE
);
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] ofs;
        logic [3:0][6:0] alias_addr;
        logic [7:0] pattern_gen_control;
        logic [7:0] pattern_gen_config;
        logic [7:0] rdata;
        logic rvalid;
        logic from_mem;
        logic [3:0] port_hit;
    } state_t;

    typedef enum logic [1:0] {
        SP_NONE = 2'b00,
        SP_PGEN = 2'b01,
        SP_MEM = 2'b10
    } space_t;

    state_t s_q;
    state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [7:0] mem_rdata;
    logic mem_we;
    logic [MEM_ADDR_W-1:0] mem_addr;
    logic [3:0] blk;
    logic val_wr;
    logic val_rd;
    space_t space;
    logic [3:0] id_match;

    // reset release through two flops, assert stays asynchronous
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    // kept outside the state struct so each flop has one driving process
    assign rst_n = rst_sync_q[1];

    assign blk = s_q.ctl[CTL_BLOCK_MSB:CTL_BLOCK_LSB]; // RULE8
    assign val_wr = I_REG_WR && (I_REG_ADDR == ADDR_IND_VAL); // RULE4 RULE5
    assign val_rd = I_REG_RD && (I_REG_ADDR == ADDR_IND_VAL); // RULE4 RULE6

    // classify the selected indirect location
    // offsets past a set's end read zero and drop writes
    always_comb begin
        space = SP_NONE;
        case (blk)
            BLK_DIGITAL: begin
                if (s_q.ofs == DIG_PATTERN_GEN_CONTROL || s_q.ofs == DIG_PATTERN_GEN_CONFIG) begin
                    space = SP_PGEN; // RULE8
                end else if ((s_q.ofs > DIG_PATTERN_GEN_CONFIG && s_q.ofs <= DIG_PGEN_LAST)
                        || (s_q.ofs >= DIG_TX0_FIRST && s_q.ofs <= DIG_TX0_LAST)
                        || (s_q.ofs >= DIG_TX1_FIRST && s_q.ofs <= DIG_TX1_LAST)) begin
                    space = SP_MEM; // RULE9
                end
            end
            BLK_LINK_SHARE: begin
                if (s_q.ofs <= SHARE_LAST) begin
                    space = SP_MEM; // RULE11
                end
            end
            BLK_TX: begin
                if (s_q.ofs <= TX_LAST) begin
                    space = SP_MEM; // RULE11
                end
            end
            default: begin
                // link channels and the broadcast set share one range
                if (blk >= BLK_LINK0 && blk <= BLK_LINK_ALL && s_q.ofs <= LINK_LAST) begin
                    space = SP_MEM; // RULE10 RULE11
                end
            end
        endcase
    end

    // broadcast writes land in the shared copy read back through code 6;
    // per-channel sets are left alone, a trade for a single-port store
    assign mem_we = val_wr && (space == SP_MEM); // RULE11
    assign mem_addr = MEM_ADDR_W'({blk[2:0], s_q.ofs[6:0]});

    ind_store #(
        .AW(MEM_ADDR_W)
    ) u_store (
        .i_clk(I_SYS_CLK),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(I_REG_WDATA),
        .o_rdata(mem_rdata)
    );

    // alias address compare per port, zero field disables the port
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_alias
            assign id_match[gp] = I_BUS_TGT_VALID && (s_q.alias_addr[gp] != 7'h00)
                && (s_q.alias_addr[gp] == I_BUS_TGT_ADDR); // RULE1 RULE2 RULE3
        end
    endgenerate

    // next state of every register in the state struct
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.from_mem = 1'b0;
        s_d.port_hit = id_match; // RULE1
        if (s_q.from_mem) begin
            s_d.rdata = mem_rdata;
        end

        // register writes; the window lands only the generator pair here
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                ADDR_IND_CTL: s_d.ctl = I_REG_WDATA; // RULE4
                ADDR_IND_OFS: s_d.ofs = I_REG_WDATA; // RULE4
                ADDR_PORT0_ID: s_d.alias_addr[0] = I_REG_WDATA[7:1]; // RULE3
                ADDR_PORT1_ID: s_d.alias_addr[1] = I_REG_WDATA[7:1]; // RULE1
                ADDR_PORT2_ID: s_d.alias_addr[2] = I_REG_WDATA[7:1]; // RULE1
                ADDR_PORT3_ID: s_d.alias_addr[3] = I_REG_WDATA[7:1]; // RULE1
                ADDR_IND_VAL: begin
                    if (space == SP_PGEN) begin
                        if (s_q.ofs == DIG_PATTERN_GEN_CONTROL) begin
                            s_d.pattern_gen_control = I_REG_WDATA; // RULE12
                        end else begin
                            s_d.pattern_gen_config = I_REG_WDATA; // RULE13 RULE14
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (I_REG_RD) begin
            s_d.rvalid = 1'b1;
            case (I_REG_ADDR)
                ADDR_IND_CTL: s_d.rdata = s_q.ctl;
                ADDR_IND_OFS: s_d.rdata = s_q.ofs;
                ADDR_PORT0_ID: s_d.rdata = {s_q.alias_addr[0], 1'b0};
                ADDR_PORT1_ID: s_d.rdata = {s_q.alias_addr[1], 1'b0};
                ADDR_PORT2_ID: s_d.rdata = {s_q.alias_addr[2], 1'b0};
                ADDR_PORT3_ID: s_d.rdata = {s_q.alias_addr[3], 1'b0};
                ADDR_IND_VAL: begin
                    case (space)
                        SP_PGEN: begin // RULE6
                            if (s_q.ofs == DIG_PATTERN_GEN_CONTROL) begin
                                s_d.rdata = s_q.pattern_gen_control; // RULE12
                            end else begin
                                s_d.rdata = s_q.pattern_gen_config; // RULE13 RULE14
                            end
                        end
                        SP_MEM: begin
                            s_d.rdata = 8'h00;
                            s_d.rvalid = 1'b0;
                            s_d.from_mem = 1'b1;
                        end
                        default: begin
                            s_d.rdata = 8'h00;
                        end
                    endcase
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end

        // store answers a cycle later; keep the handshake aligned
        if (s_q.from_mem) begin
            s_d.rvalid = 1'b1;
        end

        if ((val_wr || val_rd) && s_q.ctl[CTL_AUTOINC_BIT]) begin
            s_d.ofs = s_q.ofs + 8'h01; // RULE7
        end // RULE15: offset otherwise held
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q.ctl <= CTL_RESET;
            s_q.ofs <= OFS_RESET;
            s_q.alias_addr <= '0;
            s_q.pattern_gen_control <= PATTERN_GEN_CONTROL_RESET; // RULE12
            s_q.pattern_gen_config <= PATTERN_GEN_CONFIG_RESET; // RULE13 RULE14
            s_q.rdata <= 8'h00;
            s_q.rvalid <= 1'b0;
            s_q.from_mem <= 1'b0;
            s_q.port_hit <= 4'h0;
        end else begin
            s_q.ctl <= s_d.ctl;
            s_q.ofs <= s_d.ofs;
            s_q.alias_addr <= s_d.alias_addr;
            s_q.pattern_gen_control <= s_d.pattern_gen_control;
            s_q.pattern_gen_config <= s_d.pattern_gen_config;
            s_q.rdata <= s_d.rdata;
            s_q.rvalid <= s_d.rvalid;
            s_q.from_mem <= s_d.from_mem;
            s_q.port_hit <= s_d.port_hit;
        end
    end

    // every output comes straight from a state flop
    assign O_REG_RDATA = s_q.rdata;
    assign O_REG_RVALID = s_q.rvalid;
    assign O_PORT_HIT = s_q.port_hit;
    assign O_TEST_PATTERN_ON = s_q.pattern_gen_control[PGEN_ON_BIT]; // RULE12
    assign O_SOLID_COLOUR_SELECT = s_q.pattern_gen_config[SOLID_BIT]; // RULE13
    assign O_BAR_COUNT_CODE = s_q.pattern_gen_config[BARS_MSB:BARS_LSB]; // RULE14
endmodule : indirect_register_access

// ==== sim/ind_access_props.sv ====
// Purpose: port assertions for the register access block
// Assumes: latencies and reset values as handed over
// Notes: bound to the top module
`timescale 1ns/1ps
module ind_access_props
    import ind_access_pkg::*;
(
    // clock, reset, register port
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic O_REG_RVALID,
    // decode and pattern outputs
    input wire logic I_BUS_TGT_VALID,
    input wire logic [6:0] I_BUS_TGT_ADDR,
    input wire logic [3:0] O_PORT_HIT,
    input wire logic O_TEST_PATTERN_ON,
    input wire logic O_SOLID_COLOUR_SELECT,
    input wire logic [1:0] O_BAR_COUNT_CODE
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RSTN);
    property p_rv_main;
        I_REG_RD && I_REG_ADDR != ADDR_IND_VAL |=> O_REG_RVALID;
    endproperty
    a_rv_main: assert property (p_rv_main) else $error("no read answer");
    property p_rv_data;
        I_REG_RD && I_REG_ADDR == ADDR_IND_VAL |-> ##[1:2] O_REG_RVALID;
    endproperty
    a_rv_data: assert property (p_rv_data) else $error("no window answer");
    property p_rv_cause;
        O_REG_RVALID |-> $past(I_REG_RD) || $past(I_REG_RD, 2);
    endproperty
    a_rv_cause: assert property (p_rv_cause) else $error("stray answer");
    property p_unmapped;
        I_REG_RD && I_REG_ADDR == 8'h00 |=> O_REG_RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    property p_id_bit0;
        I_REG_RD && I_REG_ADDR[7:2] == 6'h3E |=> !O_REG_RDATA[0];
    endproperty
    a_id_bit0: assert property (p_id_bit0) else $error("alias bit0 set");
    property p_hit_zero;
        I_BUS_TGT_VALID && I_BUS_TGT_ADDR == 7'h00 |=> O_PORT_HIT == 4'h0;
    endproperty
    a_hit_zero: assert property (p_hit_zero) else $error("zero alias hit");
    property p_hit_idle;
        !I_BUS_TGT_VALID |=> O_PORT_HIT == 4'h0;
    endproperty
    a_hit_idle: assert property (p_hit_idle) else $error("hit without target");
    property p_pat_cause;
        $changed({O_TEST_PATTERN_ON, O_SOLID_COLOUR_SELECT, O_BAR_COUNT_CODE})
            |-> $past(I_REG_WR) && $past(I_REG_ADDR) == ADDR_IND_VAL;
    endproperty
    a_pat_cause: assert property (p_pat_cause) else $error("pattern moved");
endmodule : ind_access_props
bind indirect_register_access ind_access_props u_props (
    .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
    .O_REG_RVALID(O_REG_RVALID), .I_BUS_TGT_VALID(I_BUS_TGT_VALID),
    .I_BUS_TGT_ADDR(I_BUS_TGT_ADDR), .O_PORT_HIT(O_PORT_HIT),
    .O_TEST_PATTERN_ON(O_TEST_PATTERN_ON), .O_SOLID_COLOUR_SELECT(O_SOLID_COLOUR_SELECT),
    .O_BAR_COUNT_CODE(O_BAR_COUNT_CODE));

// ==== sim/bus_host_model.sv ====
// Purpose: serial bus engine model on the register and target ports
// Assumes: requests launched at the falling edge
// Notes: released lines are inverted so stale values never look valid
`timescale 1ns/1ps
module bus_host_model (
    // clock and answers
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    input wire logic [3:0] i_hit,
    // requests
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00,
    output logic o_tv = 1'b0,
    output logic [6:0] o_taddr = 7'h00
);
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        // bounded: window reads served from the store answer one cycle later than the rest
        for (int n = 0; n < 4 && !i_rvalid; n++) @(negedge i_clk);
        d = i_rvalid ? i_rdata : 8'hXX;
    endtask : read_reg
    task automatic probe(input logic [6:0] a, output logic [3:0] h);
        @(negedge i_clk);
        o_tv = 1'b1;
        o_taddr = a;
        @(negedge i_clk);
        o_tv = 1'b0;
        o_taddr = ~a;
        h = i_hit;
    endtask : probe
endmodule : bus_host_model

// ==== sim/test_indirect_register_access.sv ====
// Purpose: self-checking bench for the register access block
// Assumes: host model issues one request per call
// Notes: window table covers block codes 0 to 7 and 15
`timescale 1ns/1ps
module test_indirect_register_access import ind_access_pkg::*;;
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
    logic clk = 1'b0, rstn = 1'b0, wr, rd, tv, rv, pon, solid;
    logic [7:0] addr, wdata, rdata, d;
    logic [6:0] ta;
    logic [3:0] h, hit;
    logic [1:0] bars;
    int miscompares = 0;
    int checked = 0;
    // ctl, offset, written, expected back
    logic [31:0] tbl [13] = '{32'h04005151, 32'h08145252, 32'h0C005353, 32'h10145454,
        32'h14045555, 32'h14055600, 32'h18145757, 32'h1C1D5858, 32'h1C1E5900,
        32'h00405A5A, 32'h00715B5B, 32'h3C005C00, 32'h00005D00};
    always #4 clk = ~clk;
    indirect_register_access uut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_REG_WR(wr),
        .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rv), .I_BUS_TGT_VALID(tv), .I_BUS_TGT_ADDR(ta), .O_PORT_HIT(hit),
        .O_TEST_PATTERN_ON(pon), .O_SOLID_COLOUR_SELECT(solid), .O_BAR_COUNT_CODE(bars));
    bus_host_model host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rv), .i_hit(hit),
        .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata), .o_tv(tv), .o_taddr(ta));
    task automatic conclude;
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic ind(input logic [7:0] c, input logic [7:0] o);
        host.write_reg(ADDR_IND_CTL, c);
        host.write_reg(ADDR_IND_OFS, o);
    endtask : ind
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("pattern on", 1'b0, pon)
        `CHK("solid", 1'b0, solid)
        `CHK("bars", 2'b11, bars)
        host.read_reg(ADDR_PORT1_ID, d);
        `CHK("alias reset", ID_RESET, d)
        ind(8'h00, DIG_PATTERN_GEN_CONTROL);
        host.write_reg(ADDR_IND_VAL, 8'h01);
        @(negedge clk);
        `CHK("pattern on", 1'b1, pon)
        host.read_reg(ADDR_IND_VAL, d);
        `CHK("window", 8'h01, d)
        host.read_reg(ADDR_IND_VAL, d);
        `CHK("window again", 8'h01, d)
        host.read_reg(ADDR_IND_OFS, d);
        `CHK("offset held", DIG_PATTERN_GEN_CONTROL, d)
        ind(8'h02, DIG_PATTERN_GEN_CONTROL);
        host.write_reg(ADDR_IND_VAL, 8'h00);
        host.write_reg(ADDR_IND_VAL, 8'hA0);
        @(negedge clk);
        `CHK("pattern off", 1'b0, pon)
        `CHK("solid", 1'b1, solid)
        `CHK("bars", 2'b10, bars)
        host.read_reg(ADDR_IND_OFS, d);
        `CHK("offset step", 8'h03, d)
        for (int k = 0; k < 4; k++) begin
            ind(8'h00, DIG_PATTERN_GEN_CONFIG);
            host.write_reg(ADDR_IND_VAL, {2'b00, 2'(k), 4'h0});
            @(negedge clk);
            `CHK("bar code", 2'(k), bars)
            `CHK("bars chosen", 1'b0, solid)
        end
        foreach (tbl[i]) begin
            ind(tbl[i][31:24], tbl[i][23:16]);
            host.write_reg(ADDR_IND_VAL, tbl[i][15:8]);
            host.read_reg(ADDR_IND_VAL, d);
            `CHK("block table", tbl[i][7:0], d)
        end
        for (int p = 0; p < 4; p++) begin
            host.write_reg(ADDR_PORT0_ID + 8'(p), {7'(p + 8), 1'b1});
            host.probe(7'(p + 8), h);
            `CHK("alias hit", 4'(1 << p), h)
            host.read_reg(ADDR_PORT0_ID + 8'(p), d);
            `CHK("alias back", {7'(p + 8), 1'b0}, d)
        end
        host.write_reg(ADDR_PORT2_ID, 8'h00);
        host.probe(7'h0A, h);
        `CHK("port off", 4'h0, h)
        host.probe(7'h00, h);
        `CHK("zero target", 4'h0, h)
        host.read_reg(8'h00, d);
        `CHK("unmapped", 8'h00, d)
        conclude();
    end
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule : test_indirect_register_access
